// ==== core/gsf_pkg.sv ====
// Behaviour
// - Scheduler acts only in manual mode 1 (tuning digit 4), else base set.
// - Model position and speed gains always pass through unchanged.
// - Base set is inertia, position gain 2, speed gain 2, integral time.
// - After change, active inertia ratio is the alternate inertia parameter.
// - After change, each loop gain is base times percent ratio over 100.
// - Low digit of selection picks condition; 1 follows controller command.
// - Level is kpps, pulses or r/min according to the chosen condition.
// - Every switched gain moves by a first-order lag, time constant in ms.
// - Gains switch by the selected condition and the condition level.
// - Torque-command low-pass filter is enabled after reset.
// - Cutoff Hz is speed gain 2 times 10 over 2pi(1 + inertia x 0.1).
// - Filter parameter field enables the low-pass; disabled passes torque raw.
// - Selection 0003 compares droop pulse count against the level.
package gsf_pkg;
    localparam int CLK_MHZ     = 100;
    localparam int TICK_US     = 1;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    localparam int US_PER_MS   = 1000;
    // --------------------------------------------------------------
    // Register indices, byte address is four times the index
    // --------------------------------------------------------------
    localparam logic [5:0] IDX_TUNING  = 6'h02;
    localparam logic [5:0] IDX_INERTIA = 6'h0C;
    localparam logic [5:0] IDX_MPOS    = 6'h0D;
    localparam logic [5:0] IDX_MSPD    = 6'h0E;
    localparam logic [5:0] IDX_POS     = 6'h0F;
    localparam logic [5:0] IDX_SPD     = 6'h10;
    localparam logic [5:0] IDX_INTEG   = 6'h11;
    localparam logic [5:0] IDX_FILTER  = 6'h19;
    localparam logic [5:0] IDX_CSEL    = 6'h31;
    localparam logic [5:0] IDX_CLEVEL  = 6'h32;
    localparam logic [5:0] IDX_CTIME   = 6'h33;
    localparam logic [5:0] IDX_ALTIN   = 6'h34;
    localparam logic [5:0] IDX_POSPCT  = 6'h35;
    localparam logic [5:0] IDX_SPDPCT  = 6'h36;
    localparam logic [5:0] IDX_INTPCT  = 6'h37;
    localparam logic [5:0] IDX_STATUS  = 6'h3C;
    localparam logic [5:0] IDX_CUTOFF  = 6'h3D;
    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [15:0] RST_TUNING  = 16'h0040;
    localparam logic [15:0] RST_INERTIA = 16'h0046;
    localparam logic [15:0] RST_MPOS    = 16'h0064;
    localparam logic [15:0] RST_MSPD    = 16'h03E8;
    localparam logic [15:0] RST_POS     = 16'h0078;
    localparam logic [15:0] RST_SPD     = 16'h0BB8;
    localparam logic [15:0] RST_INTEG   = 16'h0014;
    localparam logic [15:0] RST_FILTER  = 16'h0000;
    localparam logic [15:0] RST_CSEL    = 16'h0000;
    localparam logic [15:0] RST_CLEVEL  = 16'h0032;
    localparam logic [15:0] RST_CTIME   = 16'h0001;
    localparam logic [15:0] RST_ALTIN   = 16'h0046;
    localparam logic [15:0] RST_PCT     = 16'h0064;
    // --------------------------------------------------------------
    // Field codes
    // --------------------------------------------------------------
    localparam int          TUNE_LSB     = 4;
    localparam logic [3:0]  MODE_MANUAL1 = 4'h4;
    localparam logic [3:0]  COND_CMD     = 4'h1;
    localparam logic [3:0]  COND_FREQ    = 4'h2;
    localparam logic [3:0]  COND_DROOP   = 4'h3;
    localparam logic [3:0]  COND_SPEED   = 4'h4;
    localparam logic [3:0]  LPF_OFF      = 4'h1;
    localparam logic [31:0] PCT_FULL     = 32'h0000_0064;
    localparam logic [31:0] CUT_NUM      = 32'h0000_3E2B;
    localparam logic [31:0] CUT_DEN      = 32'h0000_03E8;
    localparam logic [31:0] TEN_TENTHS   = 32'h0000_000A;
    localparam logic [31:0] ALPHA_NUM    = 32'h0000_0690;
    localparam int          ALPHA_FRAC   = 24;
    typedef enum logic [1:0] {
        GSF_BASE    = 2'b01,
        GSF_CHANGED = 2'b10
    } gsf_sel_e;
    typedef struct packed {
        logic [15:0] inertia;
        logic [15:0] pos;
        logic [15:0] spd;
        logic [15:0] integ;
    } gsf_gains_s;
endpackage : gsf_pkg

// ==== core/gsf_lag.sv ====
`timescale 1ns/10ps
module gsf_lag (
    input  wire logic        clock,  // System clock
    input  wire logic        rst,    // Async reset, active high
    input  wire logic        tick,   // One-microsecond strobe
    input  wire logic [15:0] tc_ms,  // Time constant in ms
    input  wire logic [15:0] target, // Value to approach
    output logic      [15:0] value   // Smoothed value
);
    logic [31:0]        acc_reg;
    logic               primed_reg;
    logic signed [32:0] diff;
    logic signed [32:0] step;
    logic [25:0]        den;

    assign den  = 26'(tc_ms) * 26'(gsf_pkg::US_PER_MS);
    assign diff = $signed({1'b0, target, 16'h0000}) - $signed({1'b0, acc_reg});
    assign step = (den == 26'h0) ? diff : diff / $signed({7'h00, den});
    assign value = acc_reg[31:16];

    // --------------------------------------------------------------
    // First-order lag, snaps when the remaining step underflows
    // --------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acc_reg    <= 32'h0;
            primed_reg <= 1'b0;
        end else if (!primed_reg) begin
            acc_reg    <= {target, 16'h0000};
            primed_reg <= 1'b1;
        end else if (tick) begin
            if (step == 33'sh0)
                acc_reg <= {target, 16'h0000};
            else
                acc_reg <= 32'(($signed({1'b0, acc_reg}) + step));
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    zero_tc_jump_a : assert property (@(posedge clock) disable iff (rst)
        primed_reg && tick && tc_ms == 16'h0 |=> value == $past(target))
        else $error("zero time constant did not jump");
    lag_monotone_a : assert property (@(posedge clock) disable iff (rst)
        primed_reg && tick && tc_ms != 16'h0 && $past(target) == target
        && value < target |=> value <= target)
        else $error("lag overshot its target");
endmodule : gsf_lag

// ==== core/gsf_top.sv ====
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/10ps
module gsf_top (
    input  wire logic               clock,            // System clock, 100 MHz
    input  wire logic               rst,              // Async reset, active high
    input  wire logic               psel,             // APB select
    input  wire logic               penable,          // APB enable
    input  wire logic               pwrite,           // APB write
    input  wire logic [7:0]         paddr,            // APB byte address
    input  wire logic [31:0]        pwdata,           // APB write data
    output logic      [31:0]        prdata,           // APB read data
    output logic                    pready,           // APB ready
    output logic                    pslverr,          // APB error, unmapped
    input  wire logic               gain_cmd,         // Controller gain request pin
    input  wire logic [15:0]        cmd_freq_kpps,    // Command frequency, kpps
    input  wire logic signed [15:0] droop_pulses,     // Droop, pulses
    input  wire logic signed [15:0] motor_speed,      // Motor speed, r/min
    input  wire logic signed [15:0] torque_cmd,       // Raw torque command
    output logic signed [15:0]      torque_out,       // Filtered torque command
    output logic      [15:0]        model_position_gain, // Model position gain
    output logic      [15:0]        model_speed_gain, // Model speed gain
    output gsf_pkg::gsf_gains_s     loop_gains,       // Active loop gains
    output logic                    gains_changed,    // After-change set selected
    output logic      [15:0]        lpf_cutoff_hz     // Current cutoff, Hz
);
    // --------------------------------------------------------------
    // Helpers
    // --------------------------------------------------------------
    function automatic logic [15:0] pct_scale(input logic [15:0] base,
                                              input logic [15:0] pct);
        logic [31:0] prod;
        prod = (32'(base) * 32'(pct)) / gsf_pkg::PCT_FULL;
        pct_scale = (prod > 32'h0000_FFFF) ? 16'hFFFF : prod[15:0];
    endfunction : pct_scale

    function automatic logic [15:0] mag16(input logic signed [15:0] v);
        mag16 = v[15] ? 16'(-v) : 16'(v);
    endfunction : mag16

    // --------------------------------------------------------------
    // Parameter registers
    // --------------------------------------------------------------
    logic [15:0] tuning_reg;
    logic [15:0] base_inertia_ratio_reg;
    logic [15:0] model_pos_reg;
    logic [15:0] model_spd_reg;
    logic [15:0] loop_position_gain_reg;
    logic [15:0] loop_speed_gain_reg;
    logic [15:0] speed_integral_time_reg;
    logic [15:0] filter_reg;
    logic [15:0] switch_condition_select_reg;
    logic [15:0] switch_condition_level_reg;
    logic [15:0] switch_time_constant_reg;
    logic [15:0] alt_inertia_ratio_reg;
    logic [15:0] position_gain_change_pct_reg;
    logic [15:0] speed_gain_change_pct_reg;
    logic [15:0] integral_change_pct_reg;
    logic [5:0]  idx;
    logic        wr_take;
    logic        mapped;
    logic [31:0] rd_next;

    assign idx     = paddr[7:2];
    assign wr_take = psel && penable && pready && pwrite;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tuning_reg                   <= gsf_pkg::RST_TUNING;
            base_inertia_ratio_reg       <= gsf_pkg::RST_INERTIA;
            model_pos_reg                <= gsf_pkg::RST_MPOS;
            model_spd_reg                <= gsf_pkg::RST_MSPD;
            loop_position_gain_reg       <= gsf_pkg::RST_POS;
            loop_speed_gain_reg          <= gsf_pkg::RST_SPD;
            speed_integral_time_reg      <= gsf_pkg::RST_INTEG;
            filter_reg                   <= gsf_pkg::RST_FILTER;
            switch_condition_select_reg  <= gsf_pkg::RST_CSEL;
            switch_condition_level_reg   <= gsf_pkg::RST_CLEVEL;
            switch_time_constant_reg     <= gsf_pkg::RST_CTIME;
            alt_inertia_ratio_reg        <= gsf_pkg::RST_ALTIN;
            position_gain_change_pct_reg <= gsf_pkg::RST_PCT;
            speed_gain_change_pct_reg    <= gsf_pkg::RST_PCT;
            integral_change_pct_reg      <= gsf_pkg::RST_PCT;
        end else if (wr_take) begin
            case (idx)
                gsf_pkg::IDX_TUNING:  tuning_reg                   <= pwdata[15:0];
                gsf_pkg::IDX_INERTIA: base_inertia_ratio_reg       <= pwdata[15:0];
                gsf_pkg::IDX_MPOS:    model_pos_reg                <= pwdata[15:0];
                gsf_pkg::IDX_MSPD:    model_spd_reg                <= pwdata[15:0];
                gsf_pkg::IDX_POS:     loop_position_gain_reg       <= pwdata[15:0];
                gsf_pkg::IDX_SPD:     loop_speed_gain_reg          <= pwdata[15:0];
                gsf_pkg::IDX_INTEG:   speed_integral_time_reg      <= pwdata[15:0];
                gsf_pkg::IDX_FILTER:  filter_reg                   <= pwdata[15:0];
                gsf_pkg::IDX_CSEL:    switch_condition_select_reg  <= pwdata[15:0];
                gsf_pkg::IDX_CLEVEL:  switch_condition_level_reg   <= pwdata[15:0];
                gsf_pkg::IDX_CTIME:   switch_time_constant_reg     <= pwdata[15:0];
                gsf_pkg::IDX_ALTIN:   alt_inertia_ratio_reg        <= pwdata[15:0];
                gsf_pkg::IDX_POSPCT:  position_gain_change_pct_reg <= pwdata[15:0];
                gsf_pkg::IDX_SPDPCT:  speed_gain_change_pct_reg    <= pwdata[15:0];
                gsf_pkg::IDX_INTPCT:  integral_change_pct_reg      <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // --------------------------------------------------------------
    // APB read mux and answer, one wait state
    // --------------------------------------------------------------
    gsf_pkg::gsf_sel_e sel_reg;

    always_comb begin
        mapped  = 1'b1;
        rd_next = 32'h0;
        case (idx)
            gsf_pkg::IDX_TUNING:  rd_next[15:0] = tuning_reg;
            gsf_pkg::IDX_INERTIA: rd_next[15:0] = base_inertia_ratio_reg;
            gsf_pkg::IDX_MPOS:    rd_next[15:0] = model_pos_reg;
            gsf_pkg::IDX_MSPD:    rd_next[15:0] = model_spd_reg;
            gsf_pkg::IDX_POS:     rd_next[15:0] = loop_position_gain_reg;
            gsf_pkg::IDX_SPD:     rd_next[15:0] = loop_speed_gain_reg;
            gsf_pkg::IDX_INTEG:   rd_next[15:0] = speed_integral_time_reg;
            gsf_pkg::IDX_FILTER:  rd_next[15:0] = filter_reg;
            gsf_pkg::IDX_CSEL:    rd_next[15:0] = switch_condition_select_reg;
            gsf_pkg::IDX_CLEVEL:  rd_next[15:0] = switch_condition_level_reg;
            gsf_pkg::IDX_CTIME:   rd_next[15:0] = switch_time_constant_reg;
            gsf_pkg::IDX_ALTIN:   rd_next[15:0] = alt_inertia_ratio_reg;
            gsf_pkg::IDX_POSPCT:  rd_next[15:0] = position_gain_change_pct_reg;
            gsf_pkg::IDX_SPDPCT:  rd_next[15:0] = speed_gain_change_pct_reg;
            gsf_pkg::IDX_INTPCT:  rd_next[15:0] = integral_change_pct_reg;
            gsf_pkg::IDX_STATUS:  rd_next[1:0]  = sel_reg;
            gsf_pkg::IDX_CUTOFF:  rd_next[15:0] = lpf_cutoff_hz;
            default:              mapped        = 1'b0;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            if (psel && penable && !pready && !pwrite)
                prdata <= rd_next;
        end
    end

    // --------------------------------------------------------------
    // Condition inputs and microsecond tick
    // --------------------------------------------------------------
    logic        cmd_meta_reg;
    logic        cmd_sync_reg;
    logic [6:0]  tick_cnt_reg;
    logic        tick;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cmd_meta_reg <= 1'b0;
            cmd_sync_reg <= 1'b0;
        end else begin
            cmd_meta_reg <= gain_cmd;
            cmd_sync_reg <= cmd_meta_reg;
        end
    end

    assign tick = (tick_cnt_reg == 7'(gsf_pkg::TICK_CYCLES - 1));

    always_ff @(posedge clock or posedge rst) begin
        if (rst)
            tick_cnt_reg <= 7'h0;
        else
            tick_cnt_reg <= tick ? 7'h0 : tick_cnt_reg + 7'h1;
    end

    // --------------------------------------------------------------
    // Set selection
    // --------------------------------------------------------------
    logic        manual1;
    logic        want_change;
    logic [3:0]  cond;
    logic [15:0] level;

    assign manual1 = tuning_reg[gsf_pkg::TUNE_LSB +: 4] == gsf_pkg::MODE_MANUAL1;
    assign cond    = switch_condition_select_reg[3:0];
    assign level   = switch_condition_level_reg;

    always_comb begin
        case (cond)
            gsf_pkg::COND_CMD:   want_change = cmd_sync_reg;
            gsf_pkg::COND_FREQ:  want_change = cmd_freq_kpps >= level;
            gsf_pkg::COND_DROOP: want_change = mag16(droop_pulses) >= level;
            gsf_pkg::COND_SPEED: want_change = mag16(motor_speed) >= level;
            default:             want_change = 1'b0;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sel_reg <= gsf_pkg::GSF_BASE;
        end else begin
            case (sel_reg)
                gsf_pkg::GSF_BASE:
                    if (manual1 && want_change)
                        sel_reg <= gsf_pkg::GSF_CHANGED;
                gsf_pkg::GSF_CHANGED:
                    if (!manual1 || !want_change)
                        sel_reg <= gsf_pkg::GSF_BASE;
                default:
                    sel_reg <= gsf_pkg::GSF_BASE;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Targets and smoothing
    // --------------------------------------------------------------
    gsf_pkg::gsf_gains_s base_set;
    gsf_pkg::gsf_gains_s alt_set;
    gsf_pkg::gsf_gains_s target_set;
    gsf_pkg::gsf_gains_s smooth_set;

    assign base_set = '{base_inertia_ratio_reg, loop_position_gain_reg,
                        loop_speed_gain_reg, speed_integral_time_reg};
    assign alt_set.inertia = alt_inertia_ratio_reg;
    assign alt_set.pos = pct_scale(loop_position_gain_reg,
                                   position_gain_change_pct_reg);
    assign alt_set.spd = pct_scale(loop_speed_gain_reg, speed_gain_change_pct_reg);
    assign alt_set.integ = pct_scale(speed_integral_time_reg,
                                     integral_change_pct_reg);
    assign target_set = (sel_reg == gsf_pkg::GSF_CHANGED) ? alt_set : base_set;

    genvar g;
    for (g = 0; g < 4; g++) begin : g_lag
        gsf_lag u_lag (
            .clock  (clock),
            .rst    (rst),
            .tick   (tick),
            .tc_ms  (switch_time_constant_reg),
            .target (target_set[g*16 +: 16]),
            .value  (smooth_set[g*16 +: 16])
        );
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            loop_gains          <= '0;
            gains_changed       <= 1'b0;
            model_position_gain <= 16'h0;
            model_speed_gain    <= 16'h0;
        end else begin
            loop_gains          <= smooth_set;
            gains_changed       <= sel_reg == gsf_pkg::GSF_CHANGED;
            model_position_gain <= model_pos_reg;
            model_speed_gain    <= model_spd_reg;
        end
    end

    // --------------------------------------------------------------
    // Torque low-pass filter
    // --------------------------------------------------------------
    logic [31:0]        lpf_den;
    logic [31:0]        cutoff_next;
    logic [31:0]        alpha;
    logic signed [39:0] lpf_acc_reg;
    logic signed [39:0] lpf_err;
    logic signed [63:0] lpf_step;
    logic               lpf_on;

    assign lpf_den     = gsf_pkg::TEN_TENTHS + 32'(loop_gains.inertia);
    assign cutoff_next = (32'(loop_gains.spd) * gsf_pkg::CUT_NUM)
                         / (gsf_pkg::CUT_DEN * lpf_den);
    assign alpha       = (32'(loop_gains.spd) * gsf_pkg::ALPHA_NUM) / lpf_den;
    assign lpf_on      = filter_reg[3:0] != gsf_pkg::LPF_OFF;
    assign lpf_err     = ($signed(40'(torque_cmd)) <<< 16) - lpf_acc_reg;
    assign lpf_step    = (64'(lpf_err) * $signed({1'b0, alpha})) >>> gsf_pkg::ALPHA_FRAC;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            lpf_acc_reg   <= 40'sh0;
            torque_out    <= 16'sh0;
            lpf_cutoff_hz <= 16'h0;
        end else begin
            lpf_cutoff_hz <= (cutoff_next > 32'h0000_FFFF) ? 16'hFFFF : cutoff_next[15:0];
            if (!lpf_on) begin
                lpf_acc_reg <= $signed(40'(torque_cmd)) <<< 16;
                torque_out  <= torque_cmd;
            end else begin
                if (tick)
                    lpf_acc_reg <= lpf_acc_reg + 40'(lpf_step);
                torque_out <= lpf_acc_reg[31:16];
            end
        end
    end

    // --------------------------------------------------------------
    // Checks
    // --------------------------------------------------------------
    auto_no_change_a : assert property (@(posedge clock) disable iff (rst)
        !manual1 |=> sel_reg == gsf_pkg::GSF_BASE)
        else $error("scheduler switched outside manual mode 1");
    model_gain_pass_a : assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> model_position_gain == $past(model_pos_reg)
                 && model_speed_gain == $past(model_spd_reg))
        else $error("model gains altered");
    base_target_a : assert property (@(posedge clock) disable iff (rst)
        sel_reg == gsf_pkg::GSF_BASE |-> target_set.spd == loop_speed_gain_reg
        && target_set.inertia == base_inertia_ratio_reg)
        else $error("base set not targeted");
    alt_inertia_a : assert property (@(posedge clock) disable iff (rst)
        sel_reg == gsf_pkg::GSF_CHANGED |-> target_set.inertia == alt_inertia_ratio_reg)
        else $error("alternate inertia not targeted");
    full_pct_same_a : assert property (@(posedge clock) disable iff (rst)
        speed_gain_change_pct_reg == 16'h0064 |-> alt_set.spd == loop_speed_gain_reg)
        else $error("100 percent changed the speed gain");
    cmd_follow_a : assert property (@(posedge clock) disable iff (rst)
        manual1 && cond == gsf_pkg::COND_CMD && cmd_sync_reg
        |=> sel_reg == gsf_pkg::GSF_CHANGED)
        else $error("controller command not followed");
    droop_level_a : assert property (@(posedge clock) disable iff (rst)
        manual1 && cond == gsf_pkg::COND_DROOP && mag16(droop_pulses) < level
        |=> sel_reg == gsf_pkg::GSF_BASE)
        else $error("droop below level kept changed set");
    lpf_bypass_a : assert property (@(posedge clock) disable iff (rst)
        !lpf_on |=> torque_out == $past(torque_cmd))
        else $error("disabled filter did not pass torque");
endmodule : gsf_top

// ==== verif/gsf_ctrl_model.sv ====
`timescale 1ns/10ps
module gsf_ctrl_model (
    input  wire logic               clock,        // System clock
    input  wire logic               want,         // Ask for the changed set
    input  wire logic signed [15:0] droop,        // Droop to present
    output logic                    gain_cmd,     // Gain request pin
    output logic signed [15:0]      droop_pulses  // Droop pulses
);
    // Requests leave one edge after they are asked for, like a real controller
    always_ff @(posedge clock) begin
        gain_cmd     <= want;
        droop_pulses <= droop;
    end
endmodule : gsf_ctrl_model

// ==== verif/testbench.sv ====
`timescale 1ns/10ps
module testbench;
    logic                clock = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, want = 0;
    logic [7:0]          paddr = 8'h00;
    logic [31:0]         pwdata = 32'h0, prdata, rd;
    logic                pready, pslverr, err, gain_cmd, chg;
    logic signed [15:0]  droop = 16'sh0000, dp, tq = 16'sh0123, tq_out, spd = 16'sh0000;
    logic [15:0]         mpg, msg, cut, freq = 16'h0000;
    gsf_pkg::gsf_gains_s g;
    int                  failures = 0, compares = 0, cycles = 0;
    gsf_ctrl_model i_gsf_ctrl_model (.clock(clock), .want(want), .droop(droop),
        .gain_cmd(gain_cmd), .droop_pulses(dp));
    gsf_top i_gsf_top (.clock(clock), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gain_cmd(gain_cmd), .cmd_freq_kpps(freq), .droop_pulses(dp),
        .motor_speed(spd), .torque_cmd(tq), .torque_out(tq_out),
        .model_position_gain(mpg), .model_speed_gain(msg), .loop_gains(g),
        .gains_changed(chg), .lpf_cutoff_hz(cut));
    initial forever #5 clock = ~clock;
    task automatic give_verdict;
        if (failures == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end
    task automatic check(input string what, input logic [64:0] seen, input logic [64:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // Setup, access until pready, release, then one idle edge
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [15:0] d);
        psel <= 1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {16'h0000, d};
        @(posedge clock);
        penable <= 1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clock);
    endtask : apb
    task automatic t_regs;
        apb(0, gsf_pkg::IDX_TUNING, 16'h0000);
        check("tuning", rd, 32'h0000_0040);
        apb(0, gsf_pkg::IDX_FILTER, 16'h0000);
        check("filter", rd, 32'h0000_0000);
        apb(1, 6'h3F, 16'hFFFF);
        check("unmapped", err, 1'b1);
        check("base", {g, chg}, {64'h0046_0078_0BB8_0014, 1'b0});
    endtask : t_regs
    task automatic t_cmd;
        apb(1, gsf_pkg::IDX_CTIME, 16'h0000);
        apb(1, gsf_pkg::IDX_ALTIN, 16'h0064);
        apb(1, gsf_pkg::IDX_POSPCT, 16'h0046);
        apb(1, gsf_pkg::IDX_SPDPCT, 16'h0085);
        apb(1, gsf_pkg::IDX_INTPCT, 16'h00FA);
        apb(1, gsf_pkg::IDX_CSEL, 16'h0001);
        apb(1, gsf_pkg::IDX_MPOS, 16'h0050);
        want <= 1;
        repeat (250) @(posedge clock);
        check("cmd set", {g, chg}, {64'h0064_0054_0F96_0032, 1'b1});
        check("model", {mpg, msg}, {16'h0050, gsf_pkg::RST_MSPD});
        want <= 0;
        repeat (250) @(posedge clock);
        check("cmd back", {g, chg}, {64'h0046_0078_0BB8_0014, 1'b0});
        check("cutoff", cut >= 16'h0254 && cut <= 16'h0255, 1'b1);
    endtask : t_cmd
    task automatic t_droop(input logic [15:0] tune, input logic signed [15:0] d, input logic e);
        apb(1, gsf_pkg::IDX_TUNING, tune);
        apb(1, gsf_pkg::IDX_CSEL, 16'h0003);
        apb(1, gsf_pkg::IDX_CLEVEL, 16'h0032);
        droop <= d;
        repeat (250) @(posedge clock);
        check("droop", chg, e);
    endtask : t_droop
    task automatic t_lag_filter;
        apb(1, gsf_pkg::IDX_CTIME, 16'h0001);
        droop <= 16'sh0032;
        repeat (250) @(posedge clock);
        check("lag", chg === 1'b1 && g.pos < 16'h0078 && g.pos > 16'h0054, 1'b1);
        check("filtered torque", tq_out > 16'sh0000 && tq_out < 16'sh0123, 1'b1);
        apb(1, gsf_pkg::IDX_FILTER, 16'h0001);
        tq <= 16'sh0456;
        repeat (2) @(posedge clock);
        check("raw torque", tq_out, 16'h0456);
    endtask : t_lag_filter
    task automatic t_level(input logic [3:0] c, input logic [15:0] f,
                           input logic signed [15:0] s, input logic e);
        apb(1, gsf_pkg::IDX_CSEL, {12'h000, c});
        freq <= f;
        spd <= s;
        repeat (4) @(posedge clock);
        check("level", chg, e);
    endtask : t_level
    initial begin
        repeat (4) @(posedge clock);
        rst <= 0;
        @(posedge clock);
        t_regs();
        t_cmd();
        t_droop(16'h0040, 16'sh0032, 1'b1);
        t_droop(16'h0040, 16'shFFCF, 1'b0);
        t_droop(16'h0010, 16'sh0032, 1'b0);
        t_droop(16'h0040, 16'sh0031, 1'b0);
        t_lag_filter();
        t_level(gsf_pkg::COND_FREQ, 16'h0032, 16'sh0000, 1'b1);
        t_level(gsf_pkg::COND_FREQ, 16'h0031, 16'sh0000, 1'b0);
        t_level(gsf_pkg::COND_SPEED, 16'h0000, 16'shFFCE, 1'b1);
        t_level(gsf_pkg::COND_SPEED, 16'h0000, 16'sh0031, 1'b0);
        give_verdict();
    end
endmodule : testbench
